//--- sfe_consts.vh
`ifndef SFE_CONSTS_VH
`define SFE_CONSTS_VH

// Register word indices on the Avalon-MM slave.
`define SFE_IDX_TX_DATA        4'h0
`define SFE_IDX_RX_DATA        4'h1
`define SFE_IDX_STATUS         4'h2
`define SFE_IDX_RX_PARAMS      4'h3
`define SFE_IDX_MISC_PARAMS    4'h4
`define SFE_IDX_TX_PARAMS      4'h5
`define SFE_IDX_OPTIONS        4'h7
`define SFE_IDX_MISC_CTRL      4'hA

// Enhancement option bits.
`define SFE_OPT_AUTO_FLAG      0
`define SFE_OPT_AUTO_EOM       1
`define SFE_OPT_AUTO_RTS       2
`define SFE_OPT_RX_LEVEL       3
`define SFE_OPT_REQ_TIMING     4
`define SFE_OPT_TX_LEVEL       5
`define SFE_OPT_READBACK       6
`define SFE_OPT_WMASK          8'h7F

// Fields of the parameter and control registers.
`define SFE_RXP_ENABLE         0
`define SFE_TXP_RTS            1
`define SFE_TXP_ENABLE         3
`define SFE_MISC_MODE_HI       5
`define SFE_MISC_MODE_LO       4
`define SFE_MODE_BIT_FRAME     2'h2
`define SFE_CTRL_FLAG_UNDERRUN 2

// Status register bits.
`define SFE_ST_RX_AVAIL        0
`define SFE_ST_TX_EMPTY        2
`define SFE_ST_TX_INT          3
`define SFE_ST_RX_INT          4
`define SFE_ST_RTS             5
`define SFE_ST_OVERRUN         6
`define SFE_ST_TX_IDLE         7

// Reset values and framing constants.
`define SFE_RST_BYTE           8'h00
`define SFE_FLAG_BYTE          8'h7E
`define SFE_TX_DEPTH           4
`define SFE_RX_DEPTH           16
`define SFE_RX_LEVEL           4

`endif

//--- sfe_sync2.v
`timescale 1ns/1ns
module sfe_sync2
#(
    parameter W = 1
)
(
    // Clock and reset
    input  wire         clk_sys,
    input  wire         sys_rst,
    // Data
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);

    reg [W-1:0] meta_reg;
    reg [W-1:0] sync_reg;

    // The first stage feeds only the second stage.
    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            meta_reg <= {W{1'b0}};
            sync_reg <= {W{1'b0}};
        end
        else
        begin
            meta_reg <= d;
            sync_reg <= meta_reg;
        end
    end

    assign q = sync_reg;

endmodule

//--- sfe_fifo.v
`timescale 1ns/1ns
module sfe_fifo
#(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
)
(
    // Clock and reset
    input  wire             clk_sys,
    input  wire             sys_rst,
    // Filling side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // Draining side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data,
    // Fill level
    output wire [AW:0]      level
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_reg;
    reg [AW-1:0]    rd_ptr_reg;
    reg [AW:0]      count_reg;
    wire            push;
    wire            pop;

    assign in_ready  = (count_reg != DEPTH[AW:0]);
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr_reg];
    assign level     = count_reg;
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge clk_sys)
    begin
        if (push)
            mem[wr_ptr_reg] <= in_data;
    end

    // Pointers wrap by compare so DEPTH need not be a power of two.
    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ?
                              {AW{1'b0}} : wr_ptr_reg + 1'b1;
            if (pop)
                rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ?
                              {AW{1'b0}} : rd_ptr_reg + 1'b1;
            if (push & ~pop)
                count_reg <= count_reg + 1'b1;
            else if (pop & ~push)
                count_reg <= count_reg - 1'b1;
        end
    end

endmodule

//--- sfe_top.v
// What this block does
// - With readback enabled, parameter registers and options read back their values.
// - Outgoing characters pass through a four-entry byte FIFO.
// - Tx level bit clear: transmit interrupt while any FIFO entry is free.
// - Tx level bit set: transmit interrupt only once the FIFO fully drains.
// - Rx level bit clear: receive interrupt for every character received.
// - Rx level bit set: receive interrupt only when four characters wait.
// - Status register zero shows the transmit buffer empty bit.
// - Status register zero shows the receive character available bit.
// - Automatic request-to-send release works only while option bit two is set.
// - Frame mode, no flag on underrun, control cleared: release at closing flag.
// - The release happens on the last rising transmit clock edge of the flag.
// - Option bit zero adds an opening flag; bit one resets end of message.
//
// Register access over Avalon-MM and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`include "sfe_consts.vh"
module sfe_top
#(
    parameter TX_DEPTH = `SFE_TX_DEPTH,
    parameter RX_DEPTH = `SFE_RX_DEPTH
)
(
    // Clock and reset
    input  wire        clk_sys,
    input  wire        sys_rst,
    // Avalon-MM slave
    input  wire [3:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [31:0] writedata,
    output reg  [31:0] readdata,
    output reg         waitrequest,
    // Serial line
    input  wire        transmit_clock_pin,
    input  wire        rxd,
    output reg         txd,
    output reg         rts_n,
    // Service requests
    output reg         tx_int_req,
    output reg         rx_int_req,
    output reg         dma_req_n
);

    localparam ST_IDLE = 2'h0;
    localparam ST_OPEN = 2'h1;
    localparam ST_DATA = 2'h2;
    localparam ST_FLAG = 2'h3;

    reg  [7:0] receive_params_reg;
    reg  [7:0] tx_rx_misc_params_reg;
    reg  [7:0] transmit_params_reg;
    reg  [7:0] enhancement_options_reg;
    reg  [7:0] misc_tx_rx_control_reg;
    reg        overrun_reg;
    reg  [1:0] tx_state_reg;
    reg  [2:0] tx_cnt_reg;
    reg  [7:0] tx_sh_reg;
    reg        rts_hold_reg;
    reg        txc_prev_reg;
    reg  [7:0] rx_sh_reg;
    reg  [2:0] rx_cnt_reg;
    reg  [7:0] rx_hold_reg;
    reg        rx_hold_valid_reg;
    reg  [7:0] rd_next;
    reg        tx_pop;

    wire [1:0] pin_sync;
    wire       txc_s;
    wire       rxd_s;
    wire       txc_rise;
    wire       req;
    wire       commit;
    wire       wr_tx;
    wire       rd_rx;
    wire       tx_in_ready;
    wire       tx_valid;
    wire [7:0] tx_data;
    wire [2:0] tx_level;
    wire       rx_in_ready;
    wire       rx_valid;
    wire [7:0] rx_data;
    wire [4:0] rx_level;
    wire       rts_ctrl;
    wire       auto_rts;
    wire       tx_en;
    wire       tx_empty;
    wire       tx_int_next;
    wire       rx_int_next;
    wire       flag_end;
    wire       rx_byte_done;
    wire [7:0] status;

    sfe_sync2 #(.W(2)) u_sync
    (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .d       ({rxd, transmit_clock_pin}),
        .q       (pin_sync)
    );

    assign txc_s    = pin_sync[0];
    assign rxd_s    = pin_sync[1];
    assign txc_rise = txc_s & ~txc_prev_reg;

    // Bus accesses take one wait cycle; a full transmit FIFO stalls the
    // master instead of dropping the byte.
    assign req    = read | write;
    assign commit = req & ~waitrequest;
    assign wr_tx  = commit & write & (address == `SFE_IDX_TX_DATA);
    assign rd_rx  = commit & read & (address == `SFE_IDX_RX_DATA);

    sfe_fifo #(.WIDTH(8), .DEPTH(TX_DEPTH), .AW(2)) u_tx_fifo
    (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .in_valid  (wr_tx),
        .in_ready  (tx_in_ready),
        .in_data   (writedata[7:0]),
        .out_valid (tx_valid),
        .out_ready (tx_pop),
        .out_data  (tx_data),
        .level     (tx_level)
    );

    sfe_fifo #(.WIDTH(8), .DEPTH(RX_DEPTH), .AW(4)) u_rx_fifo
    (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .in_valid  (rx_hold_valid_reg),
        .in_ready  (rx_in_ready),
        .in_data   (rx_hold_reg),
        .out_valid (rx_valid),
        .out_ready (rd_rx),
        .out_data  (rx_data),
        .level     (rx_level)
    );

    assign rts_ctrl = transmit_params_reg[`SFE_TXP_RTS];
    assign tx_en    = transmit_params_reg[`SFE_TXP_ENABLE];
    assign auto_rts = enhancement_options_reg[`SFE_OPT_AUTO_RTS]
        & ({tx_rx_misc_params_reg[`SFE_MISC_MODE_HI],
            tx_rx_misc_params_reg[`SFE_MISC_MODE_LO]}
           == `SFE_MODE_BIT_FRAME)
        & ~misc_tx_rx_control_reg[`SFE_CTRL_FLAG_UNDERRUN];
    assign flag_end = txc_rise & (tx_state_reg == ST_FLAG)
        & (tx_cnt_reg == 3'h7);
    assign tx_empty = tx_in_ready;
    assign tx_int_next = enhancement_options_reg[`SFE_OPT_TX_LEVEL] ?
        ~tx_valid : tx_in_ready;
    assign rx_int_next = enhancement_options_reg[`SFE_OPT_RX_LEVEL] ?
        (rx_level >= `SFE_RX_LEVEL) : rx_valid;
    assign rx_byte_done = txc_rise & receive_params_reg[`SFE_RXP_ENABLE]
        & (rx_cnt_reg == 3'h7);

    assign status = {tx_state_reg == ST_IDLE, overrun_reg, ~rts_n,
                     rx_int_next, tx_int_next, tx_empty, 1'b0,
                     rx_valid};

    // Read mux; write registers show zero unless readback is enabled.
    always @*
    begin
        rd_next = `SFE_RST_BYTE;
        case (address)
            `SFE_IDX_RX_DATA:
                rd_next = rx_data;
            `SFE_IDX_STATUS:
                rd_next = status;
            `SFE_IDX_RX_PARAMS:
                rd_next = receive_params_reg;
            `SFE_IDX_MISC_PARAMS:
                rd_next = tx_rx_misc_params_reg;
            `SFE_IDX_TX_PARAMS:
                rd_next = transmit_params_reg;
            `SFE_IDX_OPTIONS:
                rd_next = enhancement_options_reg;
            `SFE_IDX_MISC_CTRL:
                rd_next = misc_tx_rx_control_reg;
            default:
                rd_next = `SFE_RST_BYTE;
        endcase
        if (~enhancement_options_reg[`SFE_OPT_READBACK] &&
            address != `SFE_IDX_RX_DATA && address != `SFE_IDX_STATUS)
            rd_next = `SFE_RST_BYTE;
    end

    // Bus slave and register writes.
    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            waitrequest             <= 1'b1;
            readdata                <= 32'h0000_0000;
            receive_params_reg      <= `SFE_RST_BYTE;
            tx_rx_misc_params_reg   <= `SFE_RST_BYTE;
            transmit_params_reg     <= `SFE_RST_BYTE;
            enhancement_options_reg <= `SFE_RST_BYTE;
            misc_tx_rx_control_reg  <= `SFE_RST_BYTE;
        end
        else
        begin
            waitrequest <= 1'b1;
            if (req & waitrequest &
                ~(write & (address == `SFE_IDX_TX_DATA) & ~tx_in_ready))
            begin
                waitrequest <= 1'b0;
                readdata    <= {24'h00_0000, rd_next};
            end
            if (commit & write)
            begin
                case (address)
                    `SFE_IDX_RX_PARAMS:
                        receive_params_reg <= writedata[7:0];
                    `SFE_IDX_MISC_PARAMS:
                        tx_rx_misc_params_reg <= writedata[7:0];
                    `SFE_IDX_TX_PARAMS:
                        transmit_params_reg <= writedata[7:0];
                    `SFE_IDX_OPTIONS:
                        enhancement_options_reg <=
                            writedata[7:0] & `SFE_OPT_WMASK;
                    `SFE_IDX_MISC_CTRL:
                        misc_tx_rx_control_reg <= writedata[7:0];
                    default:
                        ;
                endcase
            end
        end
    end

    // Transmit FIFO pop happens at the transmit clock edge that loads a byte.
    always @*
    begin
        tx_pop = 1'b0;
        if (txc_rise & tx_en & tx_valid)
        begin
            case (tx_state_reg)
                ST_IDLE:
                    tx_pop = ~enhancement_options_reg[`SFE_OPT_AUTO_FLAG];
                ST_OPEN:
                    tx_pop = (tx_cnt_reg == 3'h7);
                ST_DATA:
                    tx_pop = (tx_cnt_reg == 3'h7);
                ST_FLAG:
                    tx_pop = (tx_cnt_reg == 3'h7) &
                        enhancement_options_reg[`SFE_OPT_AUTO_EOM];
                default:
                    tx_pop = 1'b0;
            endcase
        end
    end

    // Framing is kept minimal: no zero insertion and no check sequence,
    // so the closing flag follows the last data bit directly.
    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            txc_prev_reg <= 1'b0;
            tx_state_reg <= ST_IDLE;
            tx_cnt_reg   <= 3'h0;
            tx_sh_reg    <= `SFE_RST_BYTE;
            txd          <= 1'b1;
        end
        else
        begin
            txc_prev_reg <= txc_s;
            if (txc_rise)
            begin
                case (tx_state_reg)
                    ST_IDLE:
                    begin
                        txd        <= 1'b1;
                        tx_cnt_reg <= 3'h0;
                        if (tx_en & tx_valid)
                        begin
                            if (enhancement_options_reg[`SFE_OPT_AUTO_FLAG])
                            begin
                                tx_sh_reg    <= `SFE_FLAG_BYTE;
                                tx_state_reg <= ST_OPEN;
                            end
                            else
                            begin
                                tx_sh_reg    <= tx_data;
                                tx_state_reg <= ST_DATA;
                            end
                        end
                    end
                    default:
                    begin
                        txd        <= tx_sh_reg[0];
                        tx_sh_reg  <= {1'b0, tx_sh_reg[7:1]};
                        tx_cnt_reg <= tx_cnt_reg + 3'h1;
                        if (tx_cnt_reg == 3'h7)
                        begin
                            if (tx_pop)
                            begin
                                tx_sh_reg    <= tx_data;
                                tx_state_reg <= ST_DATA;
                            end
                            else if (tx_state_reg == ST_DATA)
                            begin
                                tx_sh_reg    <= `SFE_FLAG_BYTE;
                                tx_state_reg <= ST_FLAG;
                            end
                            else
                                tx_state_reg <= ST_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    // The hold keeps the output asserted after software drops the control
    // bit, so the line driver is not turned round mid-frame.
    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rts_hold_reg <= 1'b0;
            rts_n        <= 1'b1;
        end
        else
        begin
            if (rts_ctrl)
                rts_hold_reg <= 1'b1;
            else if (flag_end | ~auto_rts | (tx_state_reg == ST_IDLE))
                rts_hold_reg <= 1'b0;
            rts_n <= ~(rts_ctrl | (auto_rts & rts_hold_reg & ~flag_end));
        end
    end

    // Receive assembler; a byte waits in the holding register while the
    // FIFO is full, and a second byte arriving meanwhile is an overrun.
    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rx_sh_reg         <= `SFE_RST_BYTE;
            rx_cnt_reg        <= 3'h0;
            rx_hold_reg       <= `SFE_RST_BYTE;
            rx_hold_valid_reg <= 1'b0;
            overrun_reg       <= 1'b0;
        end
        else
        begin
            if (rx_hold_valid_reg & rx_in_ready)
                rx_hold_valid_reg <= 1'b0;
            if (txc_rise & receive_params_reg[`SFE_RXP_ENABLE])
            begin
                rx_sh_reg  <= {rxd_s, rx_sh_reg[7:1]};
                rx_cnt_reg <= rx_cnt_reg + 3'h1;
            end
            if (rx_byte_done)
            begin
                if (rx_hold_valid_reg & ~rx_in_ready)
                    ;
                else
                begin
                    rx_hold_reg       <= {rxd_s, rx_sh_reg[7:1]};
                    rx_hold_valid_reg <= 1'b1;
                end
            end
            // A new overrun wins over a clear in the same cycle.
            if (rx_byte_done & rx_hold_valid_reg & ~rx_in_ready)
                overrun_reg <= 1'b1;
            else if (commit & write & (address == `SFE_IDX_STATUS) &
                     writedata[`SFE_ST_OVERRUN])
                overrun_reg <= 1'b0;
        end
    end

    // Service request outputs.
    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tx_int_req <= 1'b0;
            rx_int_req <= 1'b0;
            dma_req_n  <= 1'b1;
        end
        else
        begin
            tx_int_req <= tx_int_next;
            rx_int_req <= rx_int_next;
            dma_req_n  <= enhancement_options_reg[`SFE_OPT_REQ_TIMING] ?
                ~(tx_level <= 3'h2) : ~tx_in_ready;
        end
    end

endmodule

//--- sfe_top_monitor.sv
`timescale 1ns/1ns
`include "sfe_consts.vh"
module sfe_top_monitor
(
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    // Register bus
    input wire logic [3:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    // Serial line and requests
    input wire logic        transmit_clock_pin,
    input wire logic        txd,
    input wire logic        rts_n,
    input wire logic        tx_int_req,
    input wire logic        dma_req_n
);
    logic [6:0] opt_reg;

    // Shadow of the option register, so readback can be judged here.
    always @(posedge clk_sys or posedge sys_rst)
        if (sys_rst)
            opt_reg <= 7'h00;
        else if (write && !waitrequest && address == `SFE_IDX_OPTIONS)
            opt_reg <= writedata[6:0];

    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    property p_wait_one;
        !waitrequest |=> waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one)
        else $error("waitrequest low for two cycles");

    property p_wait_cause;
        $fell(waitrequest) |-> $past(read || write);
    endproperty
    a_wait_cause: assert property (p_wait_cause)
        else $error("answer without a request");

    property p_rb_off;
        read && !waitrequest && address == `SFE_IDX_RX_PARAMS && !opt_reg[6]
            |-> readdata[7:0] == 8'h00;
    endproperty
    a_rb_off: assert property (p_rb_off)
        else $error("write register visible without readback");

    property p_rb_opt;
        read && !waitrequest && address == `SFE_IDX_OPTIONS && opt_reg[6]
            |-> readdata[7:0] == {1'b0, opt_reg};
    endproperty
    a_rb_opt: assert property (p_rb_opt)
        else $error("option readback wrong");

    property p_dma_tie;
        opt_reg[5:4] == 2'b00 && $past(opt_reg[5:4]) == 2'b00
            |-> dma_req_n == !tx_int_req;
    endproperty
    a_dma_tie: assert property (p_dma_tie)
        else $error("transmit request and interrupt disagree");

    property p_rts_manual;
        $rose(rts_n) && !opt_reg[2]
            |-> $past(write, 1) || $past(write, 2) || $past(write, 3);
    endproperty
    a_rts_manual: assert property (p_rts_manual)
        else $error("request to send released without a write");

    property p_rts_edge;
        $rose(rts_n) && opt_reg[2] && !$past(write, 1) && !$past(write, 2)
            |-> $past(transmit_clock_pin, 1) || $past(transmit_clock_pin, 2)
                || $past(transmit_clock_pin, 3) || $past(transmit_clock_pin, 4);
    endproperty
    a_rts_edge: assert property (p_rts_edge)
        else $error("automatic release off a clock edge");

    property p_txd_edge;
        $changed(txd)
            |-> $past(transmit_clock_pin, 1) || $past(transmit_clock_pin, 2)
                || $past(transmit_clock_pin, 3) || $past(transmit_clock_pin, 4);
    endproperty
    a_txd_edge: assert property (p_txd_edge)
        else $error("serial output moved off a clock edge");
endmodule

bind sfe_top sfe_top_monitor sfe_top_monitor_inst
(
    .clk_sys, .sys_rst, .address, .read, .write, .writedata, .readdata,
    .waitrequest, .transmit_clock_pin, .txd, .rts_n, .tx_int_req, .dma_req_n
);

//--- sfe_line_model.sv
`timescale 1ns/1ns
module sfe_line_model
#(
    parameter logic [7:0] RX_BYTE = 8'hA5
)
(
    // Control from the bench
    input  wire logic run,
    // Line
    output logic      transmit_clock_pin,
    output logic      rxd,
    output int        rises
);
    logic [2:0] idx;
    logic       live;

    initial
    begin
        transmit_clock_pin = 1'b0;
        rxd = 1'b1;
        rises = 0;
        idx = 3'h0;
        live = 1'b0;
    end

    // The clock stands still between frames; the data line then toggles,
    // since nothing holds it and a stale level must not look valid.
    always
    begin
        #400;
        if (!run)
        begin
            transmit_clock_pin = 1'b0;
            rxd = !rxd;
            idx = 3'h0;
            live = 1'b0;
        end
        else if (!live)
        begin
            rxd = RX_BYTE[0];
            idx = 3'h1;
            live = 1'b1;
        end
        else if (!transmit_clock_pin)
        begin
            transmit_clock_pin = 1'b1;
            rises = rises + 1;
        end
        else
        begin
            transmit_clock_pin = 1'b0;
            rxd = RX_BYTE[idx];
            idx = idx + 3'h1;
        end
    end
endmodule

//--- sfe_top_bench.sv
`timescale 1ns/1ns
`include "sfe_consts.vh"
module sfe_top_bench;
    logic        clk_sys   = 1'b0;
    logic        sys_rst   = 1'b1;
    logic [3:0]  address   = 4'h0;
    logic        read      = 1'b0;
    logic        write     = 1'b0;
    logic [31:0] writedata = 32'h0000_0000;
    logic        run       = 1'b0;
    wire  [31:0] readdata;
    wire         waitrequest, transmit_clock_pin, rxd, txd, rts_n;
    wire         tx_int_req, rx_int_req, dma_req_n;
    int          rises;
    int          bad_count = 0;
    int          n_tests   = 0;
    logic [7:0]  q;

    sfe_top sfe_top_inst
    (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest),
        .transmit_clock_pin(transmit_clock_pin), .rxd(rxd), .txd(txd),
        .rts_n(rts_n), .tx_int_req(tx_int_req), .rx_int_req(rx_int_req),
        .dma_req_n(dma_req_n)
    );

    sfe_line_model sfe_line_model_inst
    (
        .run(run), .transmit_clock_pin(transmit_clock_pin), .rxd(rxd),
        .rises(rises)
    );

    always #50 clk_sys = !clk_sys;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [7:0] d);
        int k;
        k = 0;
        @(posedge clk_sys);
        address <= a;
        writedata <= {24'h00_0000, d};
        write <= wr;
        read <= !wr;
        do
        begin
            @(posedge clk_sys);
            k++;
        end
        while (waitrequest !== 1'b0 && k < 50);
        q = readdata[7:0];
        write <= 1'b0;
        read <= 1'b0;
        if (k >= 50)
            chk(8'hEE, 8'h00);
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(q, e);
    endtask

    task automatic poll(input logic [7:0] m, input logic [7:0] v);
        int n;
        n = 0;
        do
        begin
            bus(1'b0, `SFE_IDX_STATUS, 8'h00);
            n++;
        end
        while ((q & m) !== v && n < 3000);
        chk(q & m, v);
    endtask

    function automatic logic pin(input int s);
        return s == 0 ? rts_n : s == 1 ? tx_int_req : rx_int_req;
    endfunction

    task automatic await(input int s, input logic v, input int lim);
        for (int k = 0; k < lim && pin(s) !== v; k++)
            @(posedge clk_sys);
        chk({7'h00, pin(s)}, {7'h00, v});
    endtask

    // Draining runs with the clock held, so only a byte already in the holding register can land mid-drain.
    task automatic drain(output int n);
        n = 0;
        bus(1'b0, `SFE_IDX_STATUS, 8'h00);
        while (q[0] === 1'b1 && n < 40)
        begin
            bus(1'b0, `SFE_IDX_RX_DATA, 8'h00);
            n++;
            bus(1'b0, `SFE_IDX_STATUS, 8'h00);
        end
    endtask

    task automatic t_regs;
        logic [3:0] ix [4] = '{4'h3, 4'h4, 4'h5, 4'hA};
        logic [7:0] vx [4] = '{8'hC4, 8'h96, 8'h64, 8'hD1};
        repeat (2) @(posedge clk_sys);
        chk({7'h00, tx_int_req}, 8'h01);
        bus(1'b1, `SFE_IDX_OPTIONS, 8'hFF);
        rd(`SFE_IDX_OPTIONS, 8'h7F);
        for (int i = 0; i < 4; i++)
            bus(1'b1, ix[i], vx[i]);
        for (int i = 0; i < 4; i++)
            rd(ix[i], vx[i]);
        rd(4'h9, 8'h00);
        bus(1'b1, `SFE_IDX_OPTIONS, 8'h00);
        rd(4'h3, 8'h00);
        for (int i = 0; i < 4; i++)
            bus(1'b1, ix[i], 8'h00);
    endtask

    task automatic t_tx_level;
        for (int i = 0; i < 4; i++)
        begin
            chk({7'h00, tx_int_req}, 8'h01);
            bus(1'b1, `SFE_IDX_TX_DATA, 8'h31 + i[7:0]);
        end
        rd(`SFE_IDX_STATUS, 8'h80);
        chk(q & 8'h04, 8'h00);
        chk({7'h00, tx_int_req}, 8'h00);
        bus(1'b1, `SFE_IDX_OPTIONS, 8'h30);
        bus(1'b1, `SFE_IDX_TX_PARAMS, 8'h08);
        run <= 1'b1;
        poll(8'h04, 8'h04);
        chk({7'h00, dma_req_n}, 8'h01);
        chk({7'h00, tx_int_req}, 8'h00);
        await(1, 1'b1, 2000);
        poll(8'h80, 8'h80);
        run <= 1'b0;
    endtask

    task automatic t_auto_rts;
        int r0;
        logic [7:0] d8;
        bus(1'b1, `SFE_IDX_TX_PARAMS, 8'h02);
        await(0, 1'b0, 5);
        bus(1'b1, `SFE_IDX_TX_PARAMS, 8'h00);
        await(0, 1'b1, 5);
        bus(1'b1, `SFE_IDX_OPTIONS, 8'h04);
        bus(1'b1, `SFE_IDX_MISC_PARAMS, 8'h20);
        bus(1'b1, `SFE_IDX_TX_PARAMS, 8'h0A);
        bus(1'b1, `SFE_IDX_TX_DATA, 8'hC3);
        r0 = rises;
        run <= 1'b1;
        for (int k = 0; k < 100 && rises - r0 < 2; k++)
            @(posedge clk_sys);
        bus(1'b1, `SFE_IDX_TX_PARAMS, 8'h08);
        await(0, 1'b1, 400);
        chk({7'h00, txd}, 8'h00);
        d8 = rises - r0;
        chk(d8, 8'h11);
        run <= 1'b0;
    endtask

    task automatic t_rx_level;
        int n;
        bus(1'b1, `SFE_IDX_OPTIONS, 8'h00);
        bus(1'b1, `SFE_IDX_RX_PARAMS, 8'h01);
        run <= 1'b1;
        poll(8'h01, 8'h01);
        await(2, 1'b1, 5);
        rd(`SFE_IDX_RX_DATA, 8'hA5);
        run <= 1'b0;
        drain(n);
        bus(1'b1, `SFE_IDX_OPTIONS, 8'h08);
        run <= 1'b1;
        poll(8'h01, 8'h01);
        chk({7'h00, rx_int_req}, 8'h00);
        await(2, 1'b1, 2000);
        run <= 1'b0;
        drain(n);
        chk(n[7:0], 8'h04);
        run <= 1'b1;
        poll(8'h40, 8'h40);
        run <= 1'b0;
        drain(n);
        chk({7'h00, n >= 16}, 8'h01);
    endtask

    task automatic conclude;
        $display("Comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        #6_000_000;
        bad_count++;
        $display("BAD %0t run took too long", $time);
        conclude;
    end

    initial
    begin
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_regs;
        t_tx_level;
        t_auto_rts;
        t_rx_level;
        conclude;
    end
endmodule
